/* fan_health_pkg.sv */
// Shared constants and types for the fan health and domain state block.
package fan_health_pkg;
    localparam int unsigned NUM_FANS       = 8;
    localparam int unsigned NUM_DOMAINS    = 4;
    localparam int unsigned NUM_GROUPS     = 2;
    localparam int unsigned NUM_PSU        = 2;
    localparam int unsigned NUM_TEMPS      = 8;
    localparam int unsigned NUM_MARGINS    = 4;
    localparam int unsigned COUNT_W        = 16;
    localparam int unsigned DUTY_W         = 8;
    localparam int unsigned MARGIN_W       = 8;

    localparam int unsigned CLOCK_MHZ      = 250;
    localparam int unsigned WINDOW_US      = 1000;
    localparam int unsigned WINDOW_CYCLES  = WINDOW_US * CLOCK_MHZ;
    localparam int unsigned GATE_MS        = 100;
    localparam int unsigned GATE_CYCLES    = GATE_MS * 1000 * CLOCK_MHZ;
    localparam int unsigned POLL_US        = 10000;
    localparam int unsigned POLL_CYCLES    = POLL_US * CLOCK_MHZ;

    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [DUTY_W-1:0]  DUTY_OFF    = 8'h00;

    typedef enum logic [1:0] {
        DOM_SLEEP,
        DOM_NOMINAL,
        DOM_BOOST
    } domain_state_t;
endpackage

/* fan_tach_counter.sv */
// Counts tachometer pulses of one fan over a fixed sampling window.
module fan_tach_counter (
    // Clock and reset.
    input  wire logic                                  clock,
    input  wire logic                                  resetn,
    // Synchronised tach level and window strobe.
    input  wire logic                                  tach,
    input  wire logic                                  window_end,
    // Count of the window just closed.
    output logic [fan_health_pkg::COUNT_W-1:0]         count,
    output logic                                       count_valid
);
    logic                                  tach_last_reg,  tach_last_next;
    logic [fan_health_pkg::COUNT_W-1:0]    acc_reg,        acc_next;
    logic [fan_health_pkg::COUNT_W-1:0]    count_reg,      count_next;
    logic                                  valid_reg,      valid_next;

    always_comb begin
        tach_last_next = tach;
        acc_next       = acc_reg;
        count_next     = count_reg;
        valid_next     = 1'b0;
        if (tach && !tach_last_reg && acc_reg != '1) begin
            acc_next = acc_reg + 16'h0001;
        end
        if (window_end) begin
            count_next = acc_next;
            acc_next   = fan_health_pkg::COUNT_RESET;
            valid_next = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tach_last_reg <= 1'b0;
            acc_reg       <= fan_health_pkg::COUNT_RESET;
            count_reg     <= fan_health_pkg::COUNT_RESET;
            valid_reg     <= 1'b0;
        end else begin
            tach_last_reg <= tach_last_next;
            acc_reg       <= acc_next;
            count_reg     <= count_next;
            valid_reg     <= valid_next;
        end
    end

    assign count       = count_reg;
    assign count_valid = valid_reg;
endmodule

/* psu_fan_monitor.sv */
// Latches power-supply fan failures reported by the PMBus poller.
module psu_fan_monitor (
    // Clock and reset.
    input  wire logic                                  clock,
    input  wire logic                                  resetn,
    // Re-arm sources.
    input  wire logic                                  system_rearm,
    input  wire logic [fan_health_pkg::NUM_PSU-1:0]    psu_present,
    // Poll answers.
    input  wire logic                                  status_valid,
    input  wire logic [fan_health_pkg::NUM_PSU-1:0]    status_fail,
    // Latched state and events.
    output logic [fan_health_pkg::NUM_PSU-1:0]         degraded,
    output logic [fan_health_pkg::NUM_PSU-1:0]         assert_event,
    output logic [fan_health_pkg::NUM_PSU-1:0]         deassert_event
);
    logic [fan_health_pkg::NUM_PSU-1:0] deg_reg,     deg_next;
    logic [fan_health_pkg::NUM_PSU-1:0] armed_reg,   armed_next;
    logic [fan_health_pkg::NUM_PSU-1:0] pres_reg,    pres_next;
    logic [fan_health_pkg::NUM_PSU-1:0] asev_reg,    asev_next;
    logic [fan_health_pkg::NUM_PSU-1:0] dsev_reg,    dsev_next;

    always_comb begin
        deg_next   = deg_reg;
        armed_next = armed_reg;
        pres_next  = psu_present;
        asev_next  = '0;
        dsev_next  = '0;
        for (int i = 0; i < fan_health_pkg::NUM_PSU; i++) begin
            // A removed and replaced supply re-arms its sensor.
            if (system_rearm || (psu_present[i] && !pres_reg[i])) begin
                armed_next[i] = 1'b1;
            end
            if (status_valid && psu_present[i]) begin
                if (status_fail[i] && !deg_reg[i]) begin
                    deg_next[i]   = 1'b1;
                    asev_next[i]  = 1'b1;
                end else if (!status_fail[i] && deg_reg[i] && armed_next[i]) begin
                    deg_next[i]   = 1'b0;
                    dsev_next[i]  = 1'b1;
                end
                armed_next[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            deg_reg   <= '0;
            armed_reg <= '1;
            pres_reg  <= '0;
            asev_reg  <= '0;
            dsev_reg  <= '0;
        end else begin
            deg_reg   <= deg_next;
            armed_reg <= armed_next;
            pres_reg  <= pres_next;
            asev_reg  <= asev_next;
            dsev_reg  <= dsev_next;
        end
    end

    assign degraded       = deg_reg;
    assign assert_event   = asev_reg;
    assign deassert_event = dsev_reg;
endmodule

/* fan_health_and_domain_state.sv */
// Fan failure latching, presence, redundancy, fans-off and per-domain state selection.
module fan_health_and_domain_state #(
    parameter int unsigned WINDOW_CYCLES = fan_health_pkg::WINDOW_CYCLES,
    parameter int unsigned GATE_CYCLES   = fan_health_pkg::GATE_CYCLES,
    parameter int unsigned POLL_CYCLES   = fan_health_pkg::POLL_CYCLES
) (
    // Clock and reset.
    input  wire logic                                                    clock,
    input  wire logic                                                    resetn,
    // Fan pins.
    input  wire logic [fan_health_pkg::NUM_FANS-1:0]                     fan_tach,
    input  wire logic [fan_health_pkg::NUM_FANS-1:0]                     fan_present_n,
    // Fan configuration.
    input  wire logic [fan_health_pkg::NUM_FANS-1:0]                     fan_hot_swap,
    input  wire logic [fan_health_pkg::NUM_FANS*fan_health_pkg::COUNT_W-1:0] fan_lower_critical,
    input  wire logic [fan_health_pkg::NUM_DOMAINS*fan_health_pkg::NUM_FANS-1:0] domain_fan_map,
    input  wire logic [fan_health_pkg::NUM_DOMAINS*fan_health_pkg::NUM_TEMPS-1:0] domain_temp_map,
    input  wire logic [fan_health_pkg::NUM_GROUPS*fan_health_pkg::NUM_FANS-1:0] group_fan_map,
    input  wire logic [fan_health_pkg::NUM_GROUPS*4-1:0]                 group_min_healthy,
    // Domain speed configuration.
    input  wire logic [fan_health_pkg::NUM_DOMAINS*fan_health_pkg::DUTY_W-1:0] domain_boost_duty,
    input  wire logic [fan_health_pkg::NUM_DOMAINS*fan_health_pkg::DUTY_W-1:0] domain_sleep_duty,
    input  wire logic [fan_health_pkg::NUM_DOMAINS-1:0]                  domain_sleep_req,
    input  wire logic [fan_health_pkg::NUM_DOMAINS*fan_health_pkg::DUTY_W-1:0] domain_nominal_duty,
    // System status.
    input  wire logic                                                    system_rearm,
    input  wire logic                                                    main_power_on,
    input  wire logic                                                    fw_update_mode,
    input  wire logic                                                    fw_corrupted,
    input  wire logic [fan_health_pkg::NUM_TEMPS-1:0]                    temp_critical,
    // Fans-off control.
    input  wire logic                                                    fans_off_enable_set,
    input  wire logic                                                    fans_off_enable_clear,
    input  wire logic [fan_health_pkg::NUM_MARGINS*fan_health_pkg::MARGIN_W-1:0] margin_reading,
    input  wire logic [fan_health_pkg::MARGIN_W-1:0]                     margin_threshold,
    // Power supply poll.
    input  wire logic [fan_health_pkg::NUM_PSU-1:0]                      psu_present,
    input  wire logic                                                    psu_status_valid,
    input  wire logic [fan_health_pkg::NUM_PSU-1:0]                      psu_status_fail,
    output logic                                                         psu_poll_req,
    // Fan sensor state.
    output logic [fan_health_pkg::NUM_FANS*fan_health_pkg::COUNT_W-1:0]  fan_reading,
    output logic [fan_health_pkg::NUM_FANS-1:0]                          fan_reading_unavailable,
    output logic [fan_health_pkg::NUM_FANS-1:0]                          fan_failed,
    output logic [fan_health_pkg::NUM_FANS-1:0]                          fan_fail_assert_event,
    output logic [fan_health_pkg::NUM_FANS-1:0]                          fan_fail_deassert_event,
    output logic [fan_health_pkg::NUM_FANS-1:0]                          fan_presence_event,
    // Redundancy sensors.
    output logic [fan_health_pkg::NUM_GROUPS-1:0]                        group_redundant,
    output logic [fan_health_pkg::NUM_GROUPS-1:0]                        redundancy_lost_event,
    output logic [fan_health_pkg::NUM_GROUPS-1:0]                        redundancy_regained_event,
    // Supply fan sensors.
    output logic [fan_health_pkg::NUM_PSU-1:0]                           psu_fan_degraded,
    output logic [fan_health_pkg::NUM_PSU-1:0]                           psu_fan_assert_event,
    output logic [fan_health_pkg::NUM_PSU-1:0]                           psu_fan_deassert_event,
    // Domain outputs.
    output logic                                                         fans_off_enabled,
    output logic                                                         fans_off_active,
    output logic [fan_health_pkg::NUM_DOMAINS*2-1:0]                     domain_state,
    output logic [fan_health_pkg::NUM_DOMAINS*fan_health_pkg::DUTY_W-1:0] domain_duty
);
    localparam int unsigned NF = fan_health_pkg::NUM_FANS;
    localparam int unsigned ND = fan_health_pkg::NUM_DOMAINS;
    localparam int unsigned NG = fan_health_pkg::NUM_GROUPS;
    localparam int unsigned CW = fan_health_pkg::COUNT_W;
    localparam int unsigned DW = fan_health_pkg::DUTY_W;
    // Counts the members of a mask that are set.
    function automatic logic [3:0] ones(input logic [NF-1:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < NF; i++) begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction
    // Pin synchronisers; settle_reg tells when the presence pair holds real pin levels.
    logic [NF-1:0] tach_s1_reg, tach_s2_reg, pres_s1_reg, pres_s2_reg;
    logic [1:0]    settle_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tach_s1_reg <= '0;
            tach_s2_reg <= '0;
            pres_s1_reg <= '0;
            pres_s2_reg <= '0;
            settle_reg  <= 2'h0;
        end else begin
            tach_s1_reg <= fan_tach;
            tach_s2_reg <= tach_s1_reg;
            pres_s1_reg <= ~fan_present_n;
            pres_s2_reg <= pres_s1_reg;
            settle_reg  <= {settle_reg[0], 1'b1};
        end
    end
    // Window and supply poll timers.
    logic [31:0] win_cnt_reg,  win_cnt_next;
    logic [31:0] poll_cnt_reg, poll_cnt_next;
    logic        win_end_reg,  win_end_next;
    logic        poll_reg,     poll_next;
    always_comb begin
        win_end_next  = (win_cnt_reg == 32'(WINDOW_CYCLES - 1));
        win_cnt_next  = win_end_next ? 32'h0000_0000 : win_cnt_reg + 32'h0000_0001;
        poll_next     = (poll_cnt_reg == 32'(POLL_CYCLES - 1));
        poll_cnt_next = poll_next ? 32'h0000_0000 : poll_cnt_reg + 32'h0000_0001;
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            win_cnt_reg  <= '0;
            poll_cnt_reg <= '0;
            win_end_reg  <= 1'b0;
            poll_reg     <= 1'b0;
        end else begin
            win_cnt_reg  <= win_cnt_next;
            poll_cnt_reg <= poll_cnt_next;
            win_end_reg  <= win_end_next;
            poll_reg     <= poll_next;
        end
    end

    // Per-fan tach counting.
    logic [NF*CW-1:0] count_w;
    logic [NF-1:0]    count_valid_w;
    for (genvar g = 0; g < NF; g++) begin : g_tach
        fan_tach_counter u_cnt (
            .clock       (clock),
            .resetn      (resetn),
            .tach        (tach_s2_reg[g]),
            .window_end  (win_end_reg),
            .count       (count_w[g*CW +: CW]),
            .count_valid (count_valid_w[g])
        );
    end
    // Fans-off mode.
    logic       fo_en_reg,  fo_en_next;
    logic       fo_act_reg, fo_act_next;
    always_comb begin
        // A set in the same cycle as a clear wins.
        fo_en_next = fans_off_enable_set || (fo_en_reg && !fans_off_enable_clear);
        fo_act_next = 1'b0;
        for (int m = 0; m < fan_health_pkg::NUM_MARGINS; m++) begin
            if (margin_reading[m*fan_health_pkg::MARGIN_W +: fan_health_pkg::MARGIN_W] < margin_threshold) begin
                fo_act_next = fo_en_reg;
            end
        end
    end
    // Fan sensors: readings, latched failures, presence.
    logic [NF*CW-1:0] rd_reg,    rd_next;
    logic [NF-1:0]    unav_reg,  unav_next;
    logic [NF-1:0]    fail_reg,  fail_next;
    logic [NF-1:0]    armed_reg, armed_next;
    logic [NF-1:0]    pres_reg,  pres_next;
    logic [NF-1:0]    pres_ok_reg, pres_ok_next;
    logic [NF-1:0]    fa_reg, fa_next, fd_reg, fd_next, pe_reg, pe_next;
    logic [NF-1:0]    miss_reg,  miss_next;
    logic [NF*32-1:0] low_cnt_reg, low_cnt_next;
    always_comb begin
        rd_next      = rd_reg;
        unav_next    = unav_reg;
        fail_next    = fail_reg;
        armed_next   = armed_reg;
        pres_next    = pres_s2_reg;
        pres_ok_next = pres_ok_reg | {NF{main_power_on && settle_reg[1]}};
        fa_next      = '0;
        fd_next      = '0;
        pe_next      = '0;
        miss_next    = miss_reg;
        low_cnt_next = low_cnt_reg;
        for (int f = 0; f < NF; f++) begin
            armed_next[f] = armed_reg[f] || system_rearm;
            if (pres_s2_reg[f] != pres_reg[f] && fan_hot_swap[f]) begin
                armed_next[f] = 1'b1;
                pe_next[f]    = pres_ok_reg[f];
            end
            // Removal is not seen while the fans are stopped, nor before the pins have settled.
            if (!fo_act_reg && settle_reg[1]) begin
                miss_next[f] = fan_hot_swap[f] && !pres_s2_reg[f];
            end
            if (fo_act_reg || miss_next[f]) begin
                unav_next[f] = 1'b1;
            end else if (count_valid_w[f]) begin
                unav_next[f] = 1'b0;
                rd_next[f*CW +: CW] = count_w[f*CW +: CW];
                if (count_w[f*CW +: CW] < fan_lower_critical[f*CW +: CW]) begin
                    // Only a slow reading that outlasts the gated-power outage is a failure.
                    low_cnt_next[f*32 +: 32] = low_cnt_reg[f*32 +: 32] + 32'(WINDOW_CYCLES);
                    if (low_cnt_next[f*32 +: 32] > 32'(GATE_CYCLES) && !fail_reg[f]) begin
                        fail_next[f] = 1'b1;
                        fa_next[f]   = 1'b1;
                    end
                end else begin
                    low_cnt_next[f*32 +: 32] = '0;
                    if (fail_reg[f] && armed_next[f]) begin
                        fail_next[f] = 1'b0;
                        fd_next[f]   = 1'b1;
                    end
                end
                armed_next[f] = 1'b0;
            end
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fo_en_reg   <= 1'b0;
            fo_act_reg  <= 1'b0;
            rd_reg      <= '0;
            unav_reg    <= '1;
            fail_reg    <= '0;
            armed_reg   <= '1;
            pres_reg    <= '0;
            pres_ok_reg <= '0;
            fa_reg      <= '0;
            fd_reg      <= '0;
            pe_reg      <= '0;
            miss_reg    <= '0;
            low_cnt_reg <= '0;
        end else begin
            fo_en_reg   <= fo_en_next;
            fo_act_reg  <= fo_act_next;
            rd_reg      <= rd_next;
            unav_reg    <= unav_next;
            fail_reg    <= fail_next;
            armed_reg   <= armed_next;
            pres_reg    <= pres_next;
            pres_ok_reg <= pres_ok_next;
            fa_reg      <= fa_next;
            fd_reg      <= fd_next;
            pe_reg      <= pe_next;
            miss_reg    <= miss_next;
            low_cnt_reg <= low_cnt_next;
        end
    end
    // Redundancy sensors and domain state.
    logic [NG-1:0]    red_reg, red_next, rl_reg, rl_next, rg_reg, rg_next;
    logic [ND*2-1:0]  st_reg,  st_next;
    logic [ND*DW-1:0] duty_reg, duty_next;
    logic [NF-1:0]    bad;
    fan_health_pkg::domain_state_t st;
    always_comb begin
        bad       = fail_reg | miss_reg;
        red_next  = red_reg;
        rl_next   = '0;
        rg_next   = '0;
        st_next   = st_reg;
        duty_next = duty_reg;
        st        = fan_health_pkg::DOM_NOMINAL;
        for (int r = 0; r < NG; r++) begin
            red_next[r] = ones(group_fan_map[r*NF +: NF] & ~bad) >= group_min_healthy[r*4 +: 4];
            rl_next[r]  = red_reg[r] && !red_next[r];
            rg_next[r]  = !red_reg[r] && red_next[r];
        end
        for (int d = 0; d < ND; d++) begin
            if (fw_update_mode || fw_corrupted
                || |(domain_fan_map[d*NF +: NF] & bad)
                || |(domain_temp_map[d*fan_health_pkg::NUM_TEMPS +: fan_health_pkg::NUM_TEMPS] & temp_critical)) begin
                st = fan_health_pkg::DOM_BOOST;
                duty_next[d*DW +: DW] = domain_boost_duty[d*DW +: DW];
            end else if (fo_act_reg) begin
                st = fan_health_pkg::DOM_NOMINAL;
                duty_next[d*DW +: DW] = fan_health_pkg::DUTY_OFF;
            end else if (domain_sleep_req[d]) begin
                st = fan_health_pkg::DOM_SLEEP;
                duty_next[d*DW +: DW] = domain_sleep_duty[d*DW +: DW];
            end else begin
                st = fan_health_pkg::DOM_NOMINAL;
                duty_next[d*DW +: DW] = domain_nominal_duty[d*DW +: DW];
            end
            st_next[d*2 +: 2] = st;
        end
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            red_reg  <= '1;
            rl_reg   <= '0;
            rg_reg   <= '0;
            st_reg   <= '0;
            duty_reg <= '0;
        end else begin
            red_reg  <= red_next;
            rl_reg   <= rl_next;
            rg_reg   <= rg_next;
            st_reg   <= st_next;
            duty_reg <= duty_next;
        end
    end
    psu_fan_monitor u_psu (
        .clock          (clock),
        .resetn         (resetn),
        .system_rearm   (system_rearm),
        .psu_present    (psu_present),
        .status_valid   (psu_status_valid),
        .status_fail    (psu_status_fail),
        .degraded       (psu_fan_degraded),
        .assert_event   (psu_fan_assert_event),
        .deassert_event (psu_fan_deassert_event)
    );

    assign psu_poll_req              = poll_reg;
    assign fan_reading               = rd_reg;
    assign fan_reading_unavailable   = unav_reg;
    assign fan_failed                = fail_reg;
    assign fan_fail_assert_event     = fa_reg;
    assign fan_fail_deassert_event   = fd_reg;
    assign fan_presence_event        = pe_reg;
    assign group_redundant           = red_reg;
    assign redundancy_lost_event     = rl_reg;
    assign redundancy_regained_event = rg_reg;
    assign fans_off_enabled          = fo_en_reg;
    assign fans_off_active           = fo_act_reg;
    assign domain_state              = st_reg;
    assign domain_duty               = duty_reg;
endmodule

/* fan_health_assertions.sv */
// Port checker for the fan health and domain state block.
module fan_health_assertions (
    input wire logic        clock, resetn, fw_update_mode, fans_off_enable_set,
    input wire logic        fans_off_enabled, fans_off_active, psu_status_valid,
    input wire logic [1:0]  psu_status_fail, psu_present, psu_fan_degraded,
    input wire logic [7:0]  temp_critical, fan_present_n, fan_presence_event, fan_hot_swap,
    input wire logic [7:0]  fan_reading_unavailable, domain_state,
    input wire logic [31:0] domain_temp_map, domain_duty
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_pins_quiet;
        $stable(fan_present_n) [*6];
    endsequence
    a_fw_boost: assert property (fw_update_mode |=> domain_state == 8'haa)
        else $error("domains not boosted");
    a_temp_boost: assert property (|(temp_critical & domain_temp_map[23:16]) |=> domain_state[5:4] == 2'h2)
        else $error("critical temperature did not boost");
    a_off_by_cmd: assert property (!fans_off_enabled && !fans_off_enable_set |=> !fans_off_enabled)
        else $error("fans-off enabled without command");
    a_off_duty: assert property (fans_off_active && $past(fans_off_active) && domain_state[1:0] == 2'h1
        |-> domain_duty[7:0] == 8'h00)
        else $error("fans-off duty not zero");
    a_psu_set: assert property (psu_status_valid && psu_present[0] && psu_status_fail[0] |=> psu_fan_degraded[0])
        else $error("supply fan failure not flagged");
    a_psu_hold: assert property (psu_fan_degraded[0] && psu_present[0] && !psu_status_valid |=> psu_fan_degraded[0])
        else $error("supply fan flag dropped");
    a_no_ghost: assert property (s_pins_quiet |=> fan_presence_event == 8'h00)
        else $error("presence event without change");
    a_absent_unav: assert property (fan_hot_swap[1] && fan_present_n[1] [*5] |-> fan_reading_unavailable[1])
        else $error("absent fan reading available");
endmodule
bind fan_health_and_domain_state fan_health_assertions u_fan_health_assertions (.*);

/* fan_partner.sv */
// Fans and supplies: tach pulses while spinning, poll answers.
module fan_partner (
    input wire logic       clock,
    input wire logic [7:0] spin,
    input wire logic [1:0] psu_bad,
    input wire logic       psu_poll_req,
    output logic     [7:0] fan_tach,
    output logic           psu_status_valid,
    output logic     [1:0] psu_status_fail
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        fan_tach = 8'h00;
        psu_status_valid = 1'b0;
        psu_status_fail = 2'h0;
    end
    // A stopped fan holds its tach low; status is junk outside an answer.
    always @(posedge clock) begin
        fan_tach <= #1 ~fan_tach & spin;
        psu_status_valid <= #1 psu_poll_req;
        psu_status_fail <= #1 psu_poll_req ? psu_bad : ~psu_status_fail;
    end
endmodule

/* tb.sv */
// Self-checking bench for the fan health and domain state block.
module tb;
timeunit 1ns;
timeprecision 1ns;
logic clock, resetn, system_rearm, main_power_on, fw_update_mode, fw_corrupted, psu_poll_req;
logic fans_off_enable_set, fans_off_enable_clear, psu_status_valid, fans_off_enabled, fans_off_active;
logic [1:0] psu_present, psu_status_fail, psu_fan_degraded, psu_fan_assert_event, psu_fan_deassert_event;
logic [1:0] psu_bad, group_redundant, redundancy_lost_event, redundancy_regained_event;
logic [3:0] domain_sleep_req;
logic [7:0] fan_tach, fan_present_n, fan_hot_swap, temp_critical, margin_threshold, spin, fan_failed;
logic [7:0] fan_reading_unavailable, fan_fail_assert_event, fan_fail_deassert_event, fan_presence_event;
logic [7:0] domain_state, group_min_healthy;
logic [15:0] group_fan_map;
logic [31:0] domain_fan_map, domain_temp_map, domain_boost_duty, domain_sleep_duty, domain_nominal_duty;
logic [31:0] margin_reading, domain_duty;
logic [127:0] fan_lower_critical, fan_reading;
int fails, checks_done, cyc, fa_n, fd_n, pe_n, rl_n, rg_n, pa_n, pd_n;
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
fan_health_and_domain_state #(.WINDOW_CYCLES(16), .GATE_CYCLES(40), .POLL_CYCLES(20))
    u_fan_health_and_domain_state (.*);
fan_partner u_fan_partner (.*);
initial begin clock = 0; forever #2 clock = ~clock; end
always @(posedge clock) begin cyc++; if (cyc > 5000) begin fails++; end_of_test(); end end
// Event pulses stand one cycle, so they are tallied where they are settled.
always @(negedge clock) begin
    fa_n += fan_fail_assert_event[0];
    fd_n += fan_fail_deassert_event[0];
    pe_n += $countones(fan_presence_event);
    rl_n += redundancy_lost_event[0];
    rg_n += redundancy_regained_event[0];
    pa_n += psu_fan_assert_event[0];
    pd_n += psu_fan_deassert_event[0];
end
task automatic step(int n); repeat (n) @(posedge clock); #1; endtask
task automatic done(string s); $display("%s done", s); endtask
task end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
        $display("verification passed");
    else
        $display("verification failed");
    $finish;
endtask
task t_modes;
    domain_sleep_req = 4'h8; step(3);
    `CHK(domain_state, 8'h15)
    `CHK(domain_duty, 32'h20808080)
    `CHK(fan_reading[15:0], 16'h0008)
    fw_corrupted = 1; step(3);
    `CHK(domain_duty, 32'hffffffff)
    fw_corrupted = 0; fw_update_mode = 1; step(3);
    `CHK(domain_state, 8'haa)
    fw_update_mode = 0; domain_sleep_req = 0; temp_critical = 8'h04; step(3);
    `CHK(domain_state, 8'h65)
    temp_critical = 0; step(3); done("modes");
endtask
task t_fail;
    spin[0] = 0; step(20); spin[0] = 1; step(40);
    `CHK(fan_failed[0], 1'b0)
    spin[0] = 0; step(120);
    `CHK(fan_failed[0], 1'b1)
    `CHK(domain_state[1:0], 2'h2)
    `CHK(group_redundant[0], 1'b0)
    spin[0] = 1; step(60);
    `CHK(fan_failed[0], 1'b1)
    system_rearm = 1; step(1); system_rearm = 0; step(60);
    `CHK(fan_failed[0], 1'b0)
    `CHK(group_redundant, 2'h3)
    `CHK(domain_state[1:0], 2'h1)
    `CHK(fa_n, 1)
    `CHK(fd_n, 1)
    `CHK(rl_n, 1)
    `CHK(rg_n, 1)
    done("fail");
endtask
task t_swap;
    fan_present_n[1] = 1; step(6);
    `CHK(fan_reading_unavailable[1], 1'b1)
    `CHK(domain_state[3:2], 2'h2)
    fan_present_n[1] = 0; step(40);
    `CHK(fan_reading_unavailable[1], 1'b0)
    `CHK(domain_state[3:2], 2'h1)
    `CHK(pe_n, 2)
    done("swap");
endtask
task t_psu;
    psu_bad = 2'h1; step(50);
    `CHK(psu_fan_degraded, 2'h1)
    psu_bad = 0; step(50);
    `CHK(psu_fan_degraded, 2'h1)
    psu_present[0] = 0; step(2); psu_present[0] = 1; step(50);
    `CHK(psu_fan_degraded, 2'h0)
    `CHK(pa_n, 1)
    `CHK(pd_n, 1)
    done("psu");
endtask
task t_fans_off;
    margin_reading[7:0] = 8'h00; step(4);
    `CHK(fans_off_enabled, 1'b0)
    fans_off_enable_set = 1; step(1); fans_off_enable_set = 0; step(4);
    `CHK(domain_duty, 32'h0)
    `CHK(fans_off_active, 1'b1)
    fan_present_n[2] = 1; step(40);
    `CHK(domain_state[5:4], 2'h1)
    `CHK(fan_reading_unavailable[0], 1'b1)
    fans_off_enable_clear = 1; step(1); fans_off_enable_clear = 0; step(6);
    `CHK(domain_state[5:4], 2'h2)
    done("fans_off");
endtask
initial begin
    resetn = 0; system_rearm = 0; main_power_on = 1; fw_update_mode = 0; fw_corrupted = 0;
    fans_off_enable_set = 0; fans_off_enable_clear = 0; psu_present = 2'h3; psu_bad = 0;
    domain_sleep_req = 0; fan_present_n = 0; fan_hot_swap = 8'hff; temp_critical = 0; spin = 8'hff;
    margin_threshold = 8'h10; group_min_healthy = 8'h44; group_fan_map = 16'hf00f;
    domain_fan_map = 32'h08040201; domain_temp_map = 32'h08040201; margin_reading = 32'h40404040;
    domain_boost_duty = 32'hffffffff; domain_sleep_duty = 32'h20202020; domain_nominal_duty = 32'h80808080;
    fan_lower_critical = {8{16'h0004}};
    step(4); resetn = 1; step(40);
    t_modes; t_fail; t_swap; t_psu; t_fans_off;
    end_of_test;
end
endmodule
